// file: core/host_port_host.sv
// Host end: runs one read or write per command over either bus style
`timescale 1ns/100ps
module host_port_host #(
   parameter int STROBE_CYC = 2
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Bus pins
   host_port_if.host        bus,
   // Command port
   input  wire logic        style,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [1:0]  cmd_chan,
   input  wire logic [2:0]  cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_rdata
);
   typedef enum logic [1:0] {IDLE = 2'b00, SETUP = 2'b01, STROBE = 2'b10, HOLD = 2'b11} st_e;
   st_e        st_reg;
   logic [3:0] cnt_reg;
   logic       wr_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg   <= IDLE;
         cnt_reg  <= 4'h0;
         wr_reg   <= 1'b0;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         bus.style_sel     <= host_port_pkg::STYLE_SPLIT;
         bus.reg_addr      <= 3'h0;
         bus.host_data_out <= 8'h00;
         bus.host_data_oe  <= 1'b0;
         bus.rd_strobe_n   <= 1'b1;
         bus.wr_strobe_n   <= 1'b1;
         bus.chan_a_sel_n  <= 1'b1;
         bus.chan_b_sel_n  <= 1'b1;
         bus.chan_c_sel_n  <= 1'b1;
         bus.chan_d_sel_n  <= 1'b1;
      end else begin
         rsp_valid <= 1'b0;
         unique case (st_reg)
            IDLE: if (cmd_valid) begin
               st_reg    <= SETUP;
               cmd_ready <= 1'b0;
               wr_reg    <= cmd_write;
               bus.style_sel     <= style;
               bus.reg_addr      <= cmd_addr;                          // [R1]
               bus.host_data_out <= cmd_wdata;
               bus.host_data_oe  <= cmd_write;                         // [R2]
               if (style == host_port_pkg::STYLE_SPLIT) begin
                  bus.chan_a_sel_n <= cmd_chan != 2'h0;                // [R8]
                  bus.chan_b_sel_n <= cmd_chan != 2'h1;
                  bus.chan_c_sel_n <= cmd_chan != 2'h2;
                  bus.chan_d_sel_n <= cmd_chan != 2'h3;
               end else begin
                  bus.chan_a_sel_n <= 1'b1;
                  bus.chan_b_sel_n <= cmd_chan[0];                     // [R10] [R12]
                  bus.chan_c_sel_n <= cmd_chan[1];
                  bus.chan_d_sel_n <= 1'b1;                            // [R11]
                  bus.rd_strobe_n  <= 1'b1;                            // [R5]
                  bus.wr_strobe_n  <= !cmd_write;                      // [R7]
               end
            end
            SETUP: begin
               st_reg  <= STROBE;
               cnt_reg <= 4'(STROBE_CYC);
               if (bus.style_sel == host_port_pkg::STYLE_SPLIT) begin
                  bus.rd_strobe_n <= wr_reg;                           // [R4]
                  bus.wr_strobe_n <= !wr_reg;                          // [R6]
               end else
                  bus.chan_a_sel_n <= 1'b0;                            // [R9]
            end
            STROBE: if (cnt_reg == 4'h0) begin
               st_reg <= HOLD;
               // Capture at strobe release; data stays driven through rise
               if (!wr_reg) begin
                  rsp_rdata <= bus.data_in;                            // [R4]
                  rsp_valid <= 1'b1;
               end
               bus.rd_strobe_n <= 1'b1;
               if (bus.style_sel == host_port_pkg::STYLE_SPLIT)
                  bus.wr_strobe_n <= 1'b1;                             // [R6]
               bus.chan_a_sel_n <= 1'b1;
               bus.chan_b_sel_n <= 1'b1;
               bus.chan_c_sel_n <= 1'b1;
               bus.chan_d_sel_n <= 1'b1;
            end else
               cnt_reg <= cnt_reg - 4'h1;
            HOLD: begin
               st_reg <= IDLE;
               cmd_ready <= 1'b1;
               bus.host_data_oe <= 1'b0;
               bus.wr_strobe_n  <= 1'b1;
            end
         endcase
      end
   end
endmodule : host_port_host

// file: core/host_port_pkg.sv
// Shared constants for the dual-style host bus port
package host_port_pkg;
   localparam int   DATA_W      = 8;
   localparam int   REG_ADDR_W  = 3;
   localparam int   CHAN_CNT    = 4;
   localparam int   CHAN_W      = 2;
   localparam logic STYLE_SPLIT = 1'b1;
   localparam logic STYLE_SINGLE = 1'b0;
   localparam logic DIR_READ    = 1'b1;
   localparam logic DIR_WRITE   = 1'b0;
   localparam logic PIN_IDLE    = 1'b1;
   localparam logic PIN_ACTIVE  = 1'b0;
endpackage : host_port_pkg

// file: core/host_port_if.sv
// Pin bundle joining the host end and the device end
`timescale 1ns/100ps
interface host_port_if;
   logic       style_sel;
   logic [2:0] reg_addr;
   logic [7:0] dev_data_out;
   logic       dev_data_oe;
   logic [7:0] host_data_out;
   logic       host_data_oe;
   logic [7:0] data_in;
   logic       rd_strobe_n;
   logic       wr_strobe_n;
   logic       chan_a_sel_n;
   logic       chan_b_sel_n;
   logic       chan_c_sel_n;
   logic       chan_d_sel_n;

   // Resolved bus level; pull-up where nobody drives
   assign data_in = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);

   modport device (
      input  style_sel, reg_addr, data_in, rd_strobe_n, wr_strobe_n,
      input  chan_a_sel_n, chan_b_sel_n, chan_c_sel_n, chan_d_sel_n,
      output dev_data_out, dev_data_oe
   );
   modport host (
      input  data_in,
      output style_sel, reg_addr, host_data_out, host_data_oe, rd_strobe_n, wr_strobe_n,
      output chan_a_sel_n, chan_b_sel_n, chan_c_sel_n, chan_d_sel_n
   );
endinterface : host_port_if

// file: core/host_port_device.sv
// Device end: decodes bus style, selects channel register, drives data
// Summary of operation
// R1: Three-bit address picks channel register
// R2: Eight-bit bus, device drives only reads
// R3: Style pin high split, low single
// R4: Read strobe fall drives addressed byte
// R5: Single style ignores read strobe
// R6: Write strobe rise loads bus byte
// R7: Single style direction: high read, low write
// R8: Split style: one select per channel
// R9: Single style: channel A select enables
// R10: Single style: B,C selects are channel bits
// R11: Single style ignores channel D select
// R12: Channel bits binary: 00 A .. 11 D
// R13: Bus released unless read in progress
`timescale 1ns/100ps
module host_port_device #(
   parameter int DATA_W = host_port_pkg::DATA_W,
   parameter int ADDR_W = host_port_pkg::REG_ADDR_W
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Host bus pins
   host_port_if.device              bus,
   // Register file side
   output logic                     reg_wr_pulse,
   output logic                     reg_rd_pulse,
   output logic [1:0]               reg_chan,
   output logic [ADDR_W-1:0]        reg_addr,
   output logic [DATA_W-1:0]        reg_wr_data,
   input  wire logic [DATA_W-1:0]   reg_rd_data [host_port_pkg::CHAN_CNT]
);
   logic       split;
   logic       sel_any;
   logic [1:0] chan;
   logic       rd_act;
   logic       wr_act;
   logic       wr_act_reg;
   logic       rd_act_reg;
   logic       chan_addr_lo;
   logic       chan_addr_hi;
   logic [DATA_W-1:0] rd_hold_reg;

   // B and C selects carry channel address bits in single style
   assign chan_addr_lo = bus.chan_b_sel_n;                             // [R10]
   assign chan_addr_hi = bus.chan_c_sel_n;                             // [R10]

   // Priority picks lowest select if host misbehaves
   function automatic logic [1:0] split_chan(input logic [3:0] sel_n);
      split_chan = !sel_n[0] ? 2'h0 : !sel_n[1] ? 2'h1 : !sel_n[2] ? 2'h2 : 2'h3;
   endfunction : split_chan

   always_comb begin
      split = (bus.style_sel == host_port_pkg::STYLE_SPLIT);          // [R3]
      if (split) begin
         sel_any = !(bus.chan_a_sel_n & bus.chan_b_sel_n
                     & bus.chan_c_sel_n & bus.chan_d_sel_n);          // [R8]
         chan    = split_chan({bus.chan_d_sel_n, bus.chan_c_sel_n,
                               bus.chan_b_sel_n, bus.chan_a_sel_n});
         rd_act  = sel_any && bus.rd_strobe_n == host_port_pkg::PIN_ACTIVE;  // [R4]
         wr_act  = sel_any && bus.wr_strobe_n == host_port_pkg::PIN_ACTIVE;  // [R6]
      end else begin
         sel_any = (bus.chan_a_sel_n == host_port_pkg::PIN_ACTIVE);   // [R9] [R11]
         chan    = {chan_addr_hi, chan_addr_lo};                      // [R10] [R12]
         rd_act  = sel_any && bus.wr_strobe_n == host_port_pkg::DIR_READ;   // [R7] [R5]
         wr_act  = sel_any && bus.wr_strobe_n == host_port_pkg::DIR_WRITE;  // [R7]
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_act_reg <= 1'b0;
         rd_act_reg <= 1'b0;
      end else begin
         wr_act_reg <= wr_act;
         rd_act_reg <= rd_act;
      end
   end

   // Write commits on strobe rise; data sampled every cycle while write is active
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_wr_pulse <= 1'b0;
         reg_rd_pulse <= 1'b0;
         reg_chan     <= 2'h0;
         reg_addr     <= '0;
         reg_wr_data  <= '0;
      end else begin
         reg_wr_pulse <= wr_act_reg && !wr_act;                        // [R6]
         reg_rd_pulse <= rd_act && !rd_act_reg;                        // [R4]
         if (wr_act || rd_act) begin
            reg_chan <= chan;
            reg_addr <= bus.reg_addr;                                  // [R1]
         end
         if (wr_act)
            reg_wr_data <= bus.data_in;                                // [R2]
      end
   end

   // Byte held from start of read; only driven during a read and for one cycle after it ends
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_hold_reg     <= '0;
         bus.dev_data_oe <= 1'b0;
      end else begin
         if (rd_act && !rd_act_reg)
            rd_hold_reg <= reg_rd_data[chan][DATA_W-1:0];              // [R4] [R1]
         bus.dev_data_oe <= rd_act && rd_act_reg && !wr_act;           // [R13] [R2]
      end
   end

   assign bus.dev_data_out = rd_hold_reg;
endmodule : host_port_device

// file: verification/host_port_chk.sv
// Pin-level checker between the host end and the device end
`timescale 1ns/100ps
module host_port_chk (
   // Clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // Bus pins
   input wire logic       style_sel,
   input wire logic [2:0] reg_addr,
   input wire logic       dev_data_oe,
   input wire logic       host_data_oe,
   input wire logic       rd_strobe_n,
   input wire logic       wr_strobe_n,
   input wire logic       chan_a_sel_n,
   input wire logic       chan_b_sel_n,
   input wire logic       chan_c_sel_n,
   input wire logic       chan_d_sel_n
);
   logic any_sel;
   logic rd_act;
   logic wr_act;
   assign any_sel = !(chan_a_sel_n && chan_b_sel_n && chan_c_sel_n && chan_d_sel_n);
   assign rd_act = style_sel ? (!rd_strobe_n && any_sel) : (wr_strobe_n && !chan_a_sel_n);
   assign wr_act = !wr_strobe_n && (style_sel ? any_sel : !chan_a_sel_n);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_rd2; rd_act [*2]; endsequence
   sequence s_wr2; wr_act [*2]; endsequence
   sequence s_acc2; (rd_act || wr_act) [*2]; endsequence
   property p_no_clash; !(dev_data_oe && host_data_oe); endproperty
   property p_oe_cause; dev_data_oe |-> $past(rd_act); endproperty
   property p_oe_on; s_rd2 |-> ##[0:2] (dev_data_oe || !rd_act); endproperty
   property p_wr_quiet; s_wr2 |-> !dev_data_oe; endproperty
   property p_wr_drive; wr_act |-> host_data_oe; endproperty
   property p_one_sel;
      style_sel |-> $onehot0(~{chan_a_sel_n, chan_b_sel_n, chan_c_sel_n, chan_d_sel_n});
   endproperty
   property p_single_tie; !style_sel |-> (rd_strobe_n && chan_d_sel_n); endproperty
   property p_addr_hold; s_acc2 |-> $stable(reg_addr); endproperty
   property p_style_hold; s_acc2 |-> $stable(style_sel); endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
   a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
   a_oe_on: assert property (p_oe_on) else $error("read not driven");
   a_wr_quiet: assert property (p_wr_quiet) else $error("device drives in write");
   a_wr_drive: assert property (p_wr_drive) else $error("host data off in write");
   a_one_sel: assert property (p_one_sel) else $error("several selects low");
   a_single_tie: assert property (p_single_tie) else $error("unused pin not high");
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   a_style_hold: assert property (p_style_hold) else $error("style moved");
endmodule : host_port_chk

// file: verification/dual_style_host_bus_port_tb_top.sv
// Corner and random traffic from the host end through to the device end
`timescale 1ns/100ps
module dual_style_host_bus_port_tb_top;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        style = 1'b1;
   logic        cmd_valid = 1'b0;
   logic        cmd_write = 1'b0;
   logic [1:0]  cmd_chan = 2'h0;
   logic [2:0]  cmd_addr = 3'h0;
   logic [7:0]  cmd_wdata = 8'h00;
   logic [7:0]  key = 8'h3c;
   logic        cmd_ready, rsp_valid, reg_wr_pulse, reg_rd_pulse;
   logic [7:0]  rsp_rdata, reg_wr_data;
   logic [1:0]  reg_chan;
   logic [2:0]  reg_addr;
   logic [7:0]  rd_data [4];
   logic [31:0] r;
   integer      seed = 32'h900a;
   integer      errors = 0;
   integer      checks_done = 0;
   integer      rd_pulses = 0;
   host_port_if bus ();
   always #50 clk = ~clk;
   always @(posedge clk) if (reg_rd_pulse === 1'b1) rd_pulses <= rd_pulses + 1;
   function automatic logic [7:0] exp_rd(input logic [7:0] k, input logic [1:0] c,
                                         input logic [2:0] a);
      return k ^ {c, a, 3'h5};
   endfunction : exp_rd
   always_comb for (int c = 0; c < 4; c++) rd_data[c] = exp_rd(key, c[1:0], bus.reg_addr);
   host_port_host host_port_host_inst (.clk(clk), .resetn(resetn), .bus(bus), .style(style),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_chan(cmd_chan), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   host_port_device host_port_device_inst (.clk(clk), .resetn(resetn), .bus(bus),
      .reg_wr_pulse(reg_wr_pulse), .reg_rd_pulse(reg_rd_pulse), .reg_chan(reg_chan),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(rd_data));
   host_port_chk host_port_chk_inst (.clk(clk), .resetn(resetn), .style_sel(bus.style_sel),
      .reg_addr(bus.reg_addr), .dev_data_oe(bus.dev_data_oe), .host_data_oe(bus.host_data_oe),
      .rd_strobe_n(bus.rd_strobe_n), .wr_strobe_n(bus.wr_strobe_n),
      .chan_a_sel_n(bus.chan_a_sel_n), .chan_b_sel_n(bus.chan_b_sel_n),
      .chan_c_sel_n(bus.chan_c_sel_n), .chan_d_sel_n(bus.chan_d_sel_n));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic run_op(input logic s, input logic w, input logic [1:0] c,
                         input logic [2:0] a, input logic [7:0] d);
      int n;
      int p0;
      @(posedge clk);
      p0 = rd_pulses;
      style <= s;
      n = 0;
      do @(posedge clk); while (cmd_ready !== 1'b1 && ++n < 60);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_chan <= c;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      n = 0;
      do @(negedge clk); while ((w ? reg_wr_pulse : rsp_valid) !== 1'b1 && ++n < 60);
      check("done", {7'h0, n < 60}, 8'h01);
      check("rd pulses", 8'(rd_pulses - p0), {7'h0, !w});
      check("style pin", {7'h0, bus.style_sel}, {7'h0, s});
      if (w) begin
         check("wr chan", {6'h0, reg_chan}, {6'h0, c});
         check("wr addr", {5'h0, reg_addr}, {5'h0, a});
         check("wr data", reg_wr_data, d);
      end else begin
         check("rd data", rsp_rdata, exp_rd(key, c, a));
         check("rd chan", {6'h0, reg_chan}, {6'h0, c});
         check("rd addr", {5'h0, reg_addr}, {5'h0, a});
      end
   endtask : run_op
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #1000000;
      errors++;
      print_verdict();
   end
   initial begin
      r = $random(seed);
      key = r[7:0];
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      check("idle oe", {7'h0, bus.dev_data_oe}, 8'h00);
      check("idle selects", {4'h0, bus.chan_a_sel_n, bus.chan_b_sel_n, bus.chan_c_sel_n,
                             bus.chan_d_sel_n}, 8'h0f);
      // Every channel in both styles, address extremes, back to back
      for (int i = 0; i < 32; i++) begin
         run_op(i[4], i[0], i[2:1], i[3] ? 3'h7 : 3'h0, 8'hff ^ i[7:0]);
      end
      $display("corner cases done");
      repeat (40) begin
         r = $random(seed);
         run_op(r[0], r[1], r[3:2], r[6:4], r[15:8]);
      end
      $display("random traffic done");
      print_verdict();
   end
endmodule : dual_style_host_bus_port_tb_top
